// >>> verilog/tmcc_top.v
// Notes on behaviour
// - Timer-a run low clears and stops it, and timer-b in cascade; high starts both.
// - In cascade, timer-b run bit is ignored; timer-a bit 7 controls joint count.
// - Timer-a clock codes 0-5: main, main/4, ext, ext/2, ext/4, ext/8.
// - Timer-a mode decodes from timer-b and timer-a mode bits together.
// - Output-enable bit 0 keeps timer pin quiet; 1 drives timer output.
// - Timer-c run low clears and stops it; high starts counting.
// - Timer-c clock codes 0-5: main, main/16, ext, ext/2, ext/4, ext/8.
// - Timer-c mode 00 is stand-alone, 10 is PPG, others prohibited.
// - Carrier mode: NRZ 0 gives low; NRZ 1 gives carrier or steady high.
// - Buffer bit copies into current NRZ on every timer-b match.
// - With timer-a output on, NRZ writes ignored; during timer-b irq buffer transfers.
// - Mode, carrier and port registers accept bit and byte writes.
// - Reset loads port direction register with all ones.
// - Direction bit 0 turns pin output buffer on; 1 turns it off.
// - Carrier and PPG modes clear counters on low or high compare match.
`timescale 1ns/1ns
`default_nettype none
`include "tmcc_map.vh"
module tmcc_top (
  input  wire        CLK_SYS,
  input  wire        RESET,
  input  wire [15:0] CPU_ADDR,
  input  wire [7:0]  CPU_WDATA,
  input  wire        CPU_WR_BYTE,
  input  wire        CPU_WR_BIT,
  input  wire [2:0]  CPU_BIT_SEL,
  input  wire        CPU_BIT_VAL,
  input  wire        CPU_RD,
  output reg  [7:0]  CPU_RDATA,
  input  wire [1:0]  TMB_MODE,
  input  wire        TMB_RUN_IN,
  input  wire        TMB_MATCH,
  input  wire        TMB_MATCH_IRQ,
  input  wire        TMB_OUT,
  input  wire        TMA_TIMER_OUT,
  input  wire        TMA_CARRIER,
  input  wire        TMA_LOW_MATCH,
  input  wire        TMA_HIGH_MATCH,
  input  wire        TMC_TIMER_OUT,
  input  wire        TMC_LOW_MATCH,
  input  wire        TMC_HIGH_MATCH,
  input  wire [2:0]  P3_LATCH,
  input  wire [2:0]  P3_IN,
  output reg         TMA_COUNT_TICK,
  output reg         TMC_COUNT_TICK,
  output reg         TMA_RUN,
  output reg         TMB_RUN,
  output reg         TMC_RUN,
  output reg         TMA_CLEAR,
  output reg         TMB_CLEAR,
  output reg         TMC_CLEAR,
  output reg  [2:0]  TMA_MODE,
  output reg  [2:0]  TMC_MODE,
  output reg  [2:0]  P3_OUT,
  output reg  [2:0]  P3_OE_N
);

  // Merges a byte write or a single-bit write into a register value.
  function [7:0] wr_merge;
    input [7:0] old;
    input [7:0] wd;
    input       byte_wr;
    input       bit_wr;
    input [2:0] sel;
    input       bv;
    reg   [7:0] tmp;
    begin
      tmp = old;
      if (byte_wr) begin
        tmp = wd;
      end else if (bit_wr) begin
        tmp[sel] = bv;
      end
      wr_merge = tmp;
    end
  endfunction

  // Decodes timer-a operating mode from both timers' mode bits.
  function [2:0] tma_decode;
    input [1:0] bm;
    input [1:0] am;
    begin
      casez ({bm, am})
        4'b?000: tma_decode = `TMCC_MD_SOLO;
        4'b0101: tma_decode = `TMCC_MD_CASCADE;
        4'b0011: tma_decode = `TMCC_MD_CARRIER;
        4'b?010: tma_decode = `TMCC_MD_PPG;
        default: tma_decode = `TMCC_MD_BAD;
      endcase
    end
  endfunction

  reg  [7:0] tma_q;
  reg  [7:0] tmc_q;
  reg        rmc_q;
  reg        nrzb_q;
  reg        nrz_q;
  reg  [7:0] p3dir_q;
  reg  [2:0] pin_s1_q;
  reg  [2:0] pin_s2_q;
  reg  [2:0] pin_s3_q;
  reg        nrz_d;
  reg        tma_pin_d;
  reg  [7:0] rd_d;
  wire       wr_any;
  wire       hit_a;
  wire       hit_c;
  wire       hit_car;
  wire       hit_dir;
  wire [7:0] car_view;
  wire [7:0] car_new;
  wire [2:0] tma_mode;
  wire [2:0] tmc_mode;
  wire       cascade;
  wire       a_run;
  wire       c_run;
  wire       a_oe;
  wire       a_tick;
  wire       c_tick;
  wire       a_ext_rise;
  wire       c_ext_rise;

  assign wr_any   = CPU_WR_BYTE | CPU_WR_BIT;
  assign hit_a    = (CPU_ADDR == `TMCC_ADDR_TMA);
  assign hit_c    = (CPU_ADDR == `TMCC_ADDR_TMC);
  assign hit_car  = (CPU_ADDR == `TMCC_ADDR_CAR);
  assign hit_dir  = (CPU_ADDR == `TMCC_ADDR_P3DIR);
  assign car_view = {5'h00, rmc_q, nrzb_q, nrz_q};
  assign car_new  = wr_merge(car_view, CPU_WDATA, CPU_WR_BYTE, CPU_WR_BIT,
                             CPU_BIT_SEL, CPU_BIT_VAL);
  assign tma_mode = tma_decode(TMB_MODE,
                               tma_q[`TMCC_MODE_HI:`TMCC_MODE_LO]);
  assign tmc_mode = (tmc_q[`TMCC_MODE_HI:`TMCC_MODE_LO] == 2'b00) ? `TMCC_MD_SOLO :
                    (tmc_q[`TMCC_MODE_HI:`TMCC_MODE_LO] == 2'b10) ? `TMCC_MD_PPG :
                    `TMCC_MD_BAD;
  assign cascade  = (tma_mode == `TMCC_MD_CASCADE);
  assign a_run    = tma_q[`TMCC_RUN_BIT];
  assign c_run    = tmc_q[`TMCC_RUN_BIT];
  assign a_oe     = tma_q[`TMCC_OUTEN_BIT];
  assign a_ext_rise = pin_s2_q[0] & ~pin_s3_q[0];
  assign c_ext_rise = pin_s2_q[2] & ~pin_s3_q[2];

  // Mode registers; bit 6 is forced to zero.
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      tma_q <= `TMCC_RST_TMA;
      tmc_q <= `TMCC_RST_TMC;
    end else begin
      if (hit_a && wr_any) begin
        tma_q <= wr_merge(tma_q, CPU_WDATA, CPU_WR_BYTE, CPU_WR_BIT,
                          CPU_BIT_SEL, CPU_BIT_VAL) & 8'hBF;
      end
      if (hit_c && wr_any) begin
        tmc_q <= wr_merge(tmc_q, CPU_WDATA, CPU_WR_BYTE, CPU_WR_BIT,
                          CPU_BIT_SEL, CPU_BIT_VAL) & 8'hBF;
      end
    end
  end

  // Current NRZ: match transfer and irq-time rewrite take the buffer bit.
  always @* begin
    nrz_d = nrz_q;
    if (TMB_MATCH) begin
      nrz_d = (hit_car && wr_any) ? car_new[`TMCC_NRZB_BIT] : nrzb_q;
    end else if (hit_car && wr_any) begin
      if (!a_oe) begin
        nrz_d = car_new[`TMCC_NRZ_BIT];
      end else if (TMB_MATCH_IRQ) begin
        nrz_d = car_new[`TMCC_NRZB_BIT];
      end
    end
  end

  // Carrier control and port direction registers.
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      rmc_q   <= 1'b0;
      nrzb_q  <= 1'b0;
      nrz_q   <= 1'b0;
      p3dir_q <= `TMCC_RST_P3DIR;
    end else begin
      nrz_q <= nrz_d;
      if (hit_car && wr_any) begin
        rmc_q  <= car_new[`TMCC_RMC_BIT];
        nrzb_q <= car_new[`TMCC_NRZB_BIT];
      end
      if (hit_dir && wr_any) begin
        p3dir_q <= (wr_merge(p3dir_q, CPU_WDATA, CPU_WR_BYTE, CPU_WR_BIT,
                    CPU_BIT_SEL, CPU_BIT_VAL) & `TMCC_P3DIR_STORE)
                   | `TMCC_P3DIR_ONES;
      end
    end
  end

  // Pin inputs pass two flip-flops; the third stage only feeds edge detection.
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_s3_q <= 3'h0;
    end else begin
      pin_s1_q <= P3_IN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  tmcc_clksel #(
    .DIV_LOG2 (`TMCC_TMA_DIV_LOG2)
  ) u_tma_clk (
    .clk      (CLK_SYS),
    .rst      (RESET),
    .run      (a_run),
    .sel      (tma_q[`TMCC_CLKSEL_HI:`TMCC_CLKSEL_LO]),
    .ext_rise (a_ext_rise),
    .tick_q   (a_tick)
  );

  tmcc_clksel #(
    .DIV_LOG2 (`TMCC_TMC_DIV_LOG2)
  ) u_tmc_clk (
    .clk      (CLK_SYS),
    .rst      (RESET),
    .run      (c_run),
    .sel      (tmc_q[`TMCC_CLKSEL_HI:`TMCC_CLKSEL_LO]),
    .ext_rise (c_ext_rise),
    .tick_q   (c_tick)
  );

  // Timer-a pin level before the enable gate.
  always @* begin
    if (tma_mode == `TMCC_MD_CARRIER) begin
      tma_pin_d = nrz_q & (rmc_q | TMA_CARRIER);
    end else begin
      tma_pin_d = TMA_TIMER_OUT;
    end
  end

  // Read data; unmapped addresses read zero.
  always @* begin
    case (CPU_ADDR)
      `TMCC_ADDR_TMA:   rd_d = tma_q;
      `TMCC_ADDR_TMC:   rd_d = tmc_q;
      `TMCC_ADDR_CAR:   rd_d = car_view & 8'hFE;
      `TMCC_ADDR_P3DIR: rd_d = p3dir_q;
      default:          rd_d = 8'h00;
    endcase
  end

  // Registered control and pin outputs.
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      CPU_RDATA      <= 8'h00;
      TMA_COUNT_TICK <= 1'b0;
      TMC_COUNT_TICK <= 1'b0;
      TMA_RUN        <= 1'b0;
      TMB_RUN        <= 1'b0;
      TMC_RUN        <= 1'b0;
      TMA_CLEAR      <= 1'b1;
      TMB_CLEAR      <= 1'b1;
      TMC_CLEAR      <= 1'b1;
      TMA_MODE       <= `TMCC_MD_SOLO;
      TMC_MODE       <= `TMCC_MD_SOLO;
      P3_OUT         <= 3'h0;
      P3_OE_N        <= 3'h7;
    end else begin
      if (CPU_RD) begin
        CPU_RDATA <= rd_d;
      end
      TMA_COUNT_TICK <= a_tick;
      TMC_COUNT_TICK <= c_tick;
      TMA_RUN        <= a_run;
      TMB_RUN        <= cascade ? a_run : TMB_RUN_IN;
      TMC_RUN        <= c_run;
      TMA_CLEAR      <= ~a_run | (((tma_mode == `TMCC_MD_CARRIER) |
                        (tma_mode == `TMCC_MD_PPG)) &
                        (TMA_LOW_MATCH | TMA_HIGH_MATCH));
      TMB_CLEAR      <= cascade ? ~a_run : ~TMB_RUN_IN;
      TMC_CLEAR      <= ~c_run | ((tmc_mode == `TMCC_MD_PPG) &
                        (TMC_LOW_MATCH | TMC_HIGH_MATCH));
      TMA_MODE       <= tma_mode;
      TMC_MODE       <= tmc_mode;
      P3_OUT[0]      <= P3_LATCH[0] | TMB_OUT;
      P3_OUT[1]      <= P3_LATCH[1] | (a_oe & tma_pin_d);
      P3_OUT[2]      <= P3_LATCH[2] | (tmc_q[`TMCC_OUTEN_BIT] & TMC_TIMER_OUT);
      P3_OE_N        <= p3dir_q[2:0];
    end
  end
endmodule
`default_nettype wire

// >>> verilog/tmcc_map.vh
`ifndef TMCC_MAP_VH
`define TMCC_MAP_VH
// Register addresses on the CPU data bus.
`define TMCC_ADDR_TMC      16'hFF41
`define TMCC_ADDR_TMA      16'hFF4E
`define TMCC_ADDR_CAR      16'hFF4F
`define TMCC_ADDR_P3DIR    16'hFF23
// Reset values.
`define TMCC_RST_TMA       8'h00
`define TMCC_RST_TMC       8'h00
`define TMCC_RST_CAR       8'h00
`define TMCC_RST_P3DIR     8'hFF
// Timer mode register fields.
`define TMCC_RUN_BIT       7
`define TMCC_ZERO_BIT      6
`define TMCC_CLKSEL_HI     5
`define TMCC_CLKSEL_LO     3
`define TMCC_MODE_HI       2
`define TMCC_MODE_LO       1
`define TMCC_OUTEN_BIT     0
// Carrier output control fields.
`define TMCC_RMC_BIT       2
`define TMCC_NRZB_BIT      1
`define TMCC_NRZ_BIT       0
// Port direction: stored bits and bits that always read one.
`define TMCC_P3DIR_STORE   8'h1F
`define TMCC_P3DIR_ONES    8'hE0
// Decoded operating modes.
`define TMCC_MD_SOLO       3'h0
`define TMCC_MD_CASCADE    3'h1
`define TMCC_MD_CARRIER    3'h2
`define TMCC_MD_PPG        3'h3
`define TMCC_MD_BAD        3'h7
// Count clock select codes.
`define TMCC_CS_MAIN       3'h0
`define TMCC_CS_MAINDIV    3'h1
`define TMCC_CS_EXT        3'h2
`define TMCC_CS_EXT2       3'h3
`define TMCC_CS_EXT4       3'h4
`define TMCC_CS_EXT8       3'h5
// Main clock prescale exponents.
`define TMCC_TMA_DIV_LOG2  2
`define TMCC_TMC_DIV_LOG2  4
`endif

// >>> verilog/tmcc_clksel.v
`timescale 1ns/1ns
`default_nettype none
`include "tmcc_map.vh"
// Count clock selector: emits one tick per count clock period.
module tmcc_clksel #(
  parameter DIV_LOG2 = `TMCC_TMA_DIV_LOG2
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       run,
  input  wire [2:0] sel,
  input  wire       ext_rise,
  output reg        tick_q
);
  reg  [DIV_LOG2-1:0] pre_q;
  reg  [2:0]          ext_q;
  reg                 tick_d;

  always @(posedge clk) begin
    if (rst || !run) begin
      pre_q <= {DIV_LOG2{1'b0}};
      ext_q <= 3'h0;
    end else begin
      pre_q <= pre_q + {{(DIV_LOG2-1){1'b0}}, 1'b1};
      if (ext_rise) begin
        ext_q <= ext_q + 3'h1;
      end
    end
  end

  always @* begin
    case (sel)
      `TMCC_CS_MAIN:    tick_d = 1'b1;
      `TMCC_CS_MAINDIV: tick_d = &pre_q;
      `TMCC_CS_EXT:     tick_d = ext_rise;
      `TMCC_CS_EXT2:    tick_d = ext_rise & ext_q[0];
      `TMCC_CS_EXT4:    tick_d = ext_rise & (&ext_q[1:0]);
      `TMCC_CS_EXT8:    tick_d = ext_rise & (&ext_q[2:0]);
      default:          tick_d = 1'b0;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      tick_q <= 1'b0;
    end else begin
      tick_q <= run & tick_d;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tmcc_ext_src.sv
`timescale 1ns/1ns
`default_nettype none
// Drives count pulses on both timer input pins and loops the remote line back.
module tmcc_ext_src (
  input  wire logic       clk,
  input  wire logic [2:0] out,
  output wire logic [2:0] pin
);
  logic ev = 1'b0;
  assign pin = {ev, out[1], ev};
  // Each pulse is four cycles high and four low.
  task automatic burst(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk);
      ev <= 1'b1;
      repeat (4) @(posedge clk);
      ev <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/tmcc_props.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmcc_map.vh"
module tmcc_props (
  input wire logic        CLK_SYS,
  input wire logic        RESET,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [7:0]  CPU_WDATA,
  input wire logic        CPU_WR_BYTE,
  input wire logic        CPU_RD,
  input wire logic [7:0]  CPU_RDATA,
  input wire logic        TMA_RUN,
  input wire logic        TMB_RUN,
  input wire logic        TMC_RUN,
  input wire logic        TMA_CLEAR,
  input wire logic        TMC_CLEAR,
  input wire logic [2:0]  TMA_MODE,
  input wire logic [2:0]  TMC_MODE,
  input wire logic        TMC_LOW_MATCH,
  input wire logic [2:0]  P3_OE_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  sequence s_wr(a);
    CPU_WR_BYTE && CPU_ADDR == a;
  endsequence
  sequence s_rd(a);
    CPU_RD && CPU_ADDR == a;
  endsequence
  property p_rst;
    $fell(RESET) |-> P3_OE_N == 3'h7 && !TMA_RUN && !TMC_RUN;
  endproperty
  property p_run_a;
    s_wr(`TMCC_ADDR_TMA) |-> ##2 TMA_RUN == $past(CPU_WDATA[7], 2);
  endproperty
  property p_run_c;
    s_wr(`TMCC_ADDR_TMC) |-> ##2 TMC_RUN == $past(CPU_WDATA[7], 2) && TMC_CLEAR != TMC_RUN;
  endproperty
  property p_clr_a;
    !TMA_RUN |-> TMA_CLEAR;
  endproperty
  property p_casc;
    TMA_MODE == `TMCC_MD_CASCADE && $stable(TMA_MODE) && $stable(TMA_RUN) |-> TMB_RUN == TMA_RUN;
  endproperty
  property p_dir;
    s_wr(`TMCC_ADDR_P3DIR) |-> ##2 P3_OE_N == $past(CPU_WDATA[2:0], 2);
  endproperty
  property p_zero6;
    s_rd(`TMCC_ADDR_TMA) or s_rd(`TMCC_ADDR_TMC) |=> !CPU_RDATA[6];
  endproperty
  property p_ones;
    s_rd(`TMCC_ADDR_P3DIR) |=> CPU_RDATA[7:5] == 3'h7;
  endproperty
  property p_ppg;
    TMC_MODE == `TMCC_MD_PPG && TMC_RUN && TMC_LOW_MATCH |-> ##[1:2] TMC_CLEAR;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  a_run_a: assert property (p_run_a) else $error("run a");
  a_run_c: assert property (p_run_c) else $error("run c");
  a_clr_a: assert property (p_clr_a) else $error("clear a");
  a_casc: assert property (p_casc) else $error("cascade run");
  a_dir: assert property (p_dir) else $error("direction");
  a_zero6: assert property (p_zero6) else $error("bit 6");
  a_ones: assert property (p_ones) else $error("dir ones");
  a_ppg: assert property (p_ppg) else $error("ppg clear");
endmodule
`default_nettype wire

// >>> bench/tmcc_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmcc_map.vh"
module tmcc_top_test;
  logic        CLK_SYS = 1'b0, RESET = 1'b1, CPU_WR_BYTE = 1'b0, CPU_WR_BIT = 1'b0, CPU_RD = 1'b0;
  logic [15:0] CPU_ADDR = 16'h0000;
  logic [7:0]  CPU_WDATA = 8'h00, rv;
  logic [2:0]  CPU_BIT_SEL = 3'h0, P3_LATCH = 3'h0;
  logic [1:0]  TMB_MODE = 2'h0;
  logic        CPU_BIT_VAL = 0, TMB_RUN_IN = 0, TMB_MATCH = 0, TMB_MATCH_IRQ = 0, TMB_OUT = 0;
  logic        TMA_TIMER_OUT = 0, TMA_CARRIER = 0, TMA_LOW_MATCH = 0, TMA_HIGH_MATCH = 0;
  logic        TMC_TIMER_OUT = 0, TMC_LOW_MATCH = 0, TMC_HIGH_MATCH = 0;
  wire  [2:0]  P3_IN, TMA_MODE, TMC_MODE, P3_OUT, P3_OE_N;
  wire  [7:0]  CPU_RDATA;
  wire         TMA_COUNT_TICK, TMC_COUNT_TICK, TMA_RUN, TMB_RUN, TMC_RUN;
  wire         TMA_CLEAR, TMB_CLEAR, TMC_CLEAR;
  int          err_count = 0, tests_run = 0, na = 0, nc = 0;
  tmcc_top i_tmcc_top (
    .CLK_SYS, .RESET, .CPU_ADDR, .CPU_WDATA, .CPU_WR_BYTE, .CPU_WR_BIT, .CPU_BIT_SEL,
    .CPU_BIT_VAL, .CPU_RD, .CPU_RDATA, .TMB_MODE, .TMB_RUN_IN, .TMB_MATCH, .TMB_MATCH_IRQ,
    .TMB_OUT, .TMA_TIMER_OUT, .TMA_CARRIER, .TMA_LOW_MATCH, .TMA_HIGH_MATCH, .TMC_TIMER_OUT,
    .TMC_LOW_MATCH, .TMC_HIGH_MATCH, .P3_LATCH, .P3_IN, .TMA_COUNT_TICK, .TMC_COUNT_TICK,
    .TMA_RUN, .TMB_RUN, .TMC_RUN, .TMA_CLEAR, .TMB_CLEAR, .TMC_CLEAR, .TMA_MODE, .TMC_MODE,
    .P3_OUT, .P3_OE_N);
  tmcc_ext_src i_tmcc_ext_src (.clk(CLK_SYS), .out(P3_OUT), .pin(P3_IN));
  always #10 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    if (TMA_COUNT_TICK === 1'b1) na <= na + 1;
    if (TMC_COUNT_TICK === 1'b1) nc <= nc + 1;
  end
  task automatic end_of_test;
    if (err_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    CPU_ADDR <= a;
    CPU_WDATA <= d;
    CPU_WR_BYTE <= 1'b1;
    @(posedge CLK_SYS);
    CPU_WR_BYTE <= 1'b0;
  endtask
  task automatic bwr(input logic [15:0] a, input logic [2:0] b, input logic v);
    @(posedge CLK_SYS);
    CPU_ADDR <= a;
    CPU_BIT_SEL <= b;
    CPU_BIT_VAL <= v;
    CPU_WR_BIT <= 1'b1;
    @(posedge CLK_SYS);
    CPU_WR_BIT <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge CLK_SYS);
    CPU_ADDR <= a;
    CPU_RD <= 1'b1;
    @(posedge CLK_SYS);
    CPU_RD <= 1'b0;
    cyc(1);
    chk(CPU_RDATA, e);
  endtask
  task automatic mt;
    @(posedge CLK_SYS);
    TMB_MATCH <= 1'b1;
    @(posedge CLK_SYS);
    TMB_MATCH <= 1'b0;
    cyc(2);
  endtask
  function automatic logic [2:0] xa(input logic [3:0] m);
    casez (m)
      4'b?000: xa = `TMCC_MD_SOLO;
      4'b0101: xa = `TMCC_MD_CASCADE;
      4'b0011: xa = `TMCC_MD_CARRIER;
      4'b?010: xa = `TMCC_MD_PPG;
      default: xa = `TMCC_MD_BAD;
    endcase
  endfunction
  task automatic t_reg;
    rd(`TMCC_ADDR_TMA, 8'h00);
    rd(`TMCC_ADDR_CAR, 8'h00);
    rd(`TMCC_ADDR_P3DIR, 8'hff);
    rd(16'h0000, 8'h00);
    wr(`TMCC_ADDR_TMC, 8'h40);
    bwr(`TMCC_ADDR_TMA, 3'h6, 1'b1);
    rd(`TMCC_ADDR_TMC, 8'h00);
    rd(`TMCC_ADDR_TMA, 8'h00);
    bwr(`TMCC_ADDR_TMC, 3'h7, 1'b1);
    cyc(2);
    chk(TMC_RUN, 1);
    bwr(`TMCC_ADDR_TMC, 3'h7, 1'b0);
    cyc(2);
    chk(TMC_CLEAR, 1);
    wr(`TMCC_ADDR_P3DIR, 8'hfa);
    cyc(2);
    chk(P3_OE_N, 3'h2);
    bwr(`TMCC_ADDR_P3DIR, 3'h1, 1'b0);
    cyc(2);
    chk(P3_OE_N, 3'h0);
    wr(`TMCC_ADDR_P3DIR, 8'hff);
  endtask
  task automatic t_run;
    TMB_MODE <= 2'h1;
    TMB_RUN_IN <= 1'b1;
    wr(`TMCC_ADDR_TMA, 8'h02);
    cyc(2);
    chk({TMB_CLEAR, TMB_RUN}, 2'h2);
    wr(`TMCC_ADDR_TMA, 8'h82);
    TMB_RUN_IN <= 1'b0;
    cyc(2);
    chk({TMA_RUN, TMB_RUN}, 2'h3);
    wr(`TMCC_ADDR_TMA, 8'h02);
    cyc(2);
    chk({TMA_CLEAR, TMB_CLEAR, TMA_RUN}, 3'h6);
  endtask
  task automatic t_mode;
    for (int i = 0; i < 16; i++) begin
      @(posedge CLK_SYS);
      TMB_MODE <= i[3:2];
      wr(`TMCC_ADDR_TMA, {5'h0, i[1:0], 1'b0});
      cyc(2);
      chk(TMA_MODE, xa(i[3:0]));
    end
    for (int j = 0; j < 4; j++) begin
      wr(`TMCC_ADDR_TMC, {5'h0, j[1:0], 1'b0});
      cyc(2);
      chk(TMC_MODE, j == 0 ? `TMCC_MD_SOLO : j == 2 ? `TMCC_MD_PPG : `TMCC_MD_BAD);
    end
    @(posedge CLK_SYS);
    TMB_MODE <= 2'h0;
  endtask
  task automatic t_clk;
    for (int k = 0; k < 2; k++) begin
      wr(`TMCC_ADDR_TMA, k ? 8'h08 : 8'h00);
      wr(`TMCC_ADDR_TMC, k ? 8'h00 : 8'h08);
      wr(`TMCC_ADDR_TMA, k ? 8'h88 : 8'h80);
      wr(`TMCC_ADDR_TMC, k ? 8'h80 : 8'h88);
      cyc(4);
      na = 0;
      nc = 0;
      cyc(64);
      chk(na[7:0], k ? 8'h10 : 8'h40);
      chk(nc[7:0], k ? 8'h40 : 8'h04);
    end
    wr(`TMCC_ADDR_TMA, 8'h30);
    wr(`TMCC_ADDR_TMC, 8'h38);
    wr(`TMCC_ADDR_TMA, 8'hb0);
    wr(`TMCC_ADDR_TMC, 8'hb8);
    cyc(4);
    na = 0;
    nc = 0;
    cyc(32);
    chk(na[7:0], 8'h00);
    chk(nc[7:0], 8'h00);
  endtask
  task automatic t_ext;
    for (int c = 2; c < 6; c++) begin
      wr(`TMCC_ADDR_TMA, {2'h0, c[2:0], 3'h0});
      wr(`TMCC_ADDR_TMC, {2'h0, c[2:0], 3'h0});
      wr(`TMCC_ADDR_TMA, {2'h2, c[2:0], 3'h0});
      wr(`TMCC_ADDR_TMC, {2'h2, c[2:0], 3'h0});
      cyc(2);
      na = 0;
      nc = 0;
      i_tmcc_ext_src.burst(8);
      cyc(8);
      chk(na[7:0], 8'(8 >> (c - 2)));
      chk(nc[7:0], 8'(8 >> (c - 2)));
    end
    wr(`TMCC_ADDR_TMA, 8'h00);
    wr(`TMCC_ADDR_TMC, 8'h00);
  endtask
  task automatic t_nrz;
    wr(`TMCC_ADDR_P3DIR, 8'hfd);
    TMA_CARRIER <= 1'b1;
    wr(`TMCC_ADDR_TMA, 8'h06);
    wr(`TMCC_ADDR_CAR, 8'h02);
    wr(`TMCC_ADDR_TMA, 8'h87);
    cyc(2);
    chk({TMA_MODE, P3_OUT[1], P3_OE_N[1]}, {`TMCC_MD_CARRIER, 2'h0});
    mt;
    chk(P3_OUT[1], 1);
    @(posedge CLK_SYS);
    TMA_CARRIER <= 1'b0;
    cyc(2);
    chk(P3_OUT[1], 0);
    wr(`TMCC_ADDR_CAR, 8'h04);
    cyc(2);
    chk(P3_OUT[1], 1);
    mt;
    chk(P3_OUT[1], 0);
    @(posedge CLK_SYS);
    TMB_MATCH_IRQ <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    wr(`TMCC_ADDR_CAR, 8'h06);
    cyc(2);
    chk(P3_OUT[1], 1);
    @(posedge CLK_SYS);
    TMB_MATCH_IRQ <= 1'b0;
    rd(`TMCC_ADDR_CAR, 8'h06);
    wr(`TMCC_ADDR_TMA, 8'h86);
    cyc(2);
    chk(P3_OUT[1], 0);
    wr(`TMCC_ADDR_P3DIR, 8'hff);
  endtask
  task automatic t_ppg;
    @(posedge CLK_SYS);
    TMA_TIMER_OUT <= 1'b1;
    TMC_TIMER_OUT <= 1'b1;
    TMB_OUT <= 1'b1;
    wr(`TMCC_ADDR_TMA, 8'h04);
    wr(`TMCC_ADDR_TMC, 8'h04);
    cyc(2);
    chk(P3_OUT, 3'h1);
    wr(`TMCC_ADDR_TMA, 8'h85);
    wr(`TMCC_ADDR_TMC, 8'h85);
    cyc(2);
    chk(P3_OUT, 3'h7);
    for (int p = 0; p < 2; p++) begin
      @(posedge CLK_SYS);
      {TMA_LOW_MATCH, TMA_HIGH_MATCH} <= p ? 2'h2 : 2'h1;
      {TMC_LOW_MATCH, TMC_HIGH_MATCH} <= p ? 2'h1 : 2'h2;
      @(posedge CLK_SYS);
      {TMA_LOW_MATCH, TMA_HIGH_MATCH, TMC_LOW_MATCH, TMC_HIGH_MATCH} <= 4'h0;
      #1 rv[1:0] = {TMA_CLEAR, TMC_CLEAR};
      cyc(1);
      rv[3:2] = {TMA_CLEAR, TMC_CLEAR};
      chk({4'h0, rv[3:0]}, 8'h03);
    end
  endtask
  initial begin
    repeat (12) @(posedge CLK_SYS);
    RESET <= 1'b0;
    t_reg;
    t_run;
    t_mode;
    t_clk;
    t_ext;
    t_nrz;
    t_ppg;
    end_of_test;
  end
  initial begin
    #1_000_000;
    err_count++;
    end_of_test;
  end
endmodule
bind tmcc_top tmcc_props i_tmcc_props (.CLK_SYS, .RESET, .CPU_ADDR, .CPU_WDATA, .CPU_WR_BYTE,
  .CPU_RD, .CPU_RDATA, .TMA_RUN, .TMB_RUN, .TMC_RUN, .TMA_CLEAR, .TMC_CLEAR, .TMA_MODE,
  .TMC_MODE, .TMC_LOW_MATCH, .P3_OE_N);
`default_nettype wire
